//--- dv/irqack_host.sv
module irqack_host (
    input wire logic i_clk,
    output logic o_ack_n,
    output logic o_strobe_n,
    output logic o_cs_n,
    output logic o_dma_a_n,
    output logic o_dma_b_n
);
    initial begin
        {o_ack_n, o_strobe_n, o_cs_n, o_dma_a_n, o_dma_b_n} = 5'h1f;
    end
    // Select is suppressed while acknowledging, so a caller slip cannot mix cycles
    task automatic drive(input logic ack, input logic stb, input logic cs);
        @(negedge i_clk);
        o_ack_n = ~ack;
        o_strobe_n = ~stb;
        o_cs_n = ~(cs & ~ack);
        o_dma_a_n = 1'b1;
        o_dma_b_n = 1'b1;
    endtask : drive
endmodule : irqack_host

//--- dv/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import irqack_pkg::*;
    logic clk = 1'b0, rst = 1'b1, rdy = 1'b0, cin = 1'b0, chi = 1'b0;
    irqack_cfg_type cfg = '0;
    irqack_bus_type bm = IRQACK_BUS_STROBED;
    irqack_src_type src = '0;
    irqack_mask_type msk = '0;
    logic ack_n, stb_n, cs_n, da_n, db_n, irq, irq_oe_n, rd, rd_oe_n, vec_oe_n, co, co_oe_n, act;
    logic [7:0] vec, gst, p;
    int fails = 0, num_checks = 0, cyc = 0;
    always #50 clk = ~clk;
    irqack_host u_host (.i_clk(clk), .o_ack_n(ack_n), .o_strobe_n(stb_n), .o_cs_n(cs_n),
        .o_dma_a_n(da_n), .o_dma_b_n(db_n));
    irqack_core u_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_cfg(cfg), .i_bus_mode(bm), .i_src(src),
        .i_mask(msk), .i_irq_ack_in_n(ack_n), .i_strobe_n(stb_n), .i_chip_sel_n(cs_n),
        .i_dma_grant_chan_a_n(da_n), .i_dma_grant_chan_b_n(db_n), .i_cycle_ready(rdy),
        .i_chain_enable_in(cin), .i_chain_addr_hi(chi), .o_irq_out(irq), .o_irq_oe_n(irq_oe_n),
        .o_cycle_ready_ack_out(rd), .o_cycle_ready_ack_oe_n(rd_oe_n), .o_vec_data(vec),
        .o_vec_oe_n(vec_oe_n), .o_chain_enable_out(co), .o_chain_enable_oe_n(co_oe_n),
        .o_global_source_status(gst), .o_irq_active(act));
    function automatic logic [7:0] pend_f(input irqack_src_type s, input irqack_mask_type m, input logic pin);
        logic [23:0] v;
        v = {s.port_status & ~m.port_mask, s.status_high & ~m.mask_high, s.status_low & ~m.mask_low};
        pend_f = 8'h00;
        for (int g = 0; g < 6; g++)
            pend_f[g] = (|v[g*4 +: 4]) && (g < 4 || pin);
    endfunction : pend_f
    function automatic logic [2:0] first_f(input logic [7:0] pv);
        first_f = 3'h0;
        for (int g = 7; g >= 0; g--)
            if (pv[g])
                first_f = 3'(g);
    endfunction : first_f
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    // Acknowledge the pending request, check the vector, then retire it
    task automatic service(input logic [7:0] pv);
        u_host.drive(1'b1, 1'b0, 1'b0);
        wt(3);
        if (bm == IRQACK_BUS_STROBED)
            chk(vec_oe_n, 1'b1);
        u_host.drive(1'b1, 1'b1, 1'b0);
        wt(3);
        chk(vec_oe_n, 1'b0);
        chk(vec, {cfg.vec_base, first_f(pv)});
        src = '0;
        if (bm == IRQACK_BUS_TWO_CYCLE) begin
            u_host.drive(1'b0, 1'b0, 1'b0);
            wt(2);
            chk(act, 1'b1);
            u_host.drive(1'b1, 1'b1, 1'b0);
            wt(2);
        end
        u_host.drive(1'b0, 1'b0, 1'b0);
        wt(3);
        chk(act, 1'b0);
    endtask : service
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(98));
        wt(4);
        rst = 1'b0;
        for (int i = 0; i < 40; i++) begin
            cfg.vec_base = 5'($urandom());
            cfg.port_in_irq = 1'($urandom());
            bm = irqack_bus_type'(i[0]);
            src = irqack_src_type'(24'($urandom()));
            msk = irqack_mask_type'(24'($urandom()));
            if (i < 2) begin
                src = '1;
                msk = (i == 0) ? irqack_mask_type'(24'h00000f) : '1;
            end
            wt(3);
            p = pend_f(src, msk, cfg.port_in_irq);
            chk(act, |p);
            chk(gst, p);
            if (|p)
                service(p);
        end
        msk = '0;
        src = '0;
        for (int m = 0; m < 3; m++) begin
            cfg.drive_mode = (m == 0) ? DRIVE_OPEN_DRAIN : (m == 1) ? DRIVE_PUSH_LOW : DRIVE_PUSH_HIGH;
            src.status_low = 8'h10;
            wt(3);
            chk({irq, irq_oe_n}, {cfg.drive_mode == DRIVE_PUSH_HIGH, 1'b0});
            src = '0;
            wt(3);
            if (m == 0)
                chk(irq_oe_n, 1'b1);
            else
                chk({irq, irq_oe_n}, {cfg.drive_mode == DRIVE_PUSH_LOW, 1'b0});
        end
        // Wrong slave address must be ignored, then the right one served
        cfg.slave_addr = 2'h2;
        {chi, cin} = 2'h1;
        src.status_high = 8'h01;
        wt(3);
        u_host.drive(1'b1, 1'b1, 1'b0);
        wt(3);
        chk(vec_oe_n, 1'b1);
        u_host.drive(1'b0, 1'b0, 1'b0);
        {chi, cin} = 2'h2;
        wt(2);
        service(8'h04);
        cfg.cascade_mode = CASCADE_DAISY;
        cin = 1'b0;
        src.status_low = 8'h01;
        wt(3);
        chk({act, co, co_oe_n}, 3'h0);
        cin = 1'b1;
        wt(3);
        chk({act, co}, 2'h2);
        cin = 1'b0;
        wt(3);
        chk({act, co}, 2'h0);
        cin = 1'b1;
        wt(3);
        service(8'h01);
        wt(2);
        chk(co, 1'b1);
        u_host.drive(1'b0, 1'b1, 1'b1);
        wt(3);
        chk(rd_oe_n, 1'b1);
        rdy = 1'b1;
        wt(3);
        chk({rd, rd_oe_n}, 2'h0);
        u_host.drive(1'b0, 1'b0, 1'b0);
        wt(3);
        chk(rd_oe_n, 1'b1);
        give_verdict();
    end
endmodule : tb

//--- rtl/irqack_core.sv
module irqack_core (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire irqack_pkg::irqack_cfg_type i_cfg,
    input wire irqack_pkg::irqack_bus_type i_bus_mode,
    input wire irqack_pkg::irqack_src_type i_src,
    input wire irqack_pkg::irqack_mask_type i_mask,
    input wire logic i_irq_ack_in_n,
    input wire logic i_strobe_n,
    input wire logic i_chip_sel_n,
    input wire logic i_dma_grant_chan_a_n,
    input wire logic i_dma_grant_chan_b_n,
    input wire logic i_cycle_ready,
    input wire logic i_chain_enable_in,
    input wire logic i_chain_addr_hi,
    output logic o_irq_out,
    output logic o_irq_oe_n,
    output logic o_cycle_ready_ack_out,
    output logic o_cycle_ready_ack_oe_n,
    output logic [irqack_pkg::VEC_W-1:0] o_vec_data,
    output logic o_vec_oe_n,
    output logic o_chain_enable_out,
    output logic o_chain_enable_oe_n,
    output logic [irqack_pkg::NUM_GROUPS-1:0] o_global_source_status,
    output logic o_irq_active
);
    import irqack_pkg::*;

    function automatic logic [2:0] top_group(input logic [NUM_GROUPS-1:0] g);
        logic [2:0] r;
        r = VEC_GROUP_LSB;
        for (int i = NUM_GROUPS - 1; i >= 0; i--) begin
            if (g[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : top_group

    logic [NUM_GROUPS-1:0] grp;
    logic pending;
    logic daisy;
    logic chain_ok;
    logic ack_now;
    logic ack_q;
    logic ack_fall;
    logic ack_rise;
    logic accepted_q;
    logic second_q;
    logic irq_q;
    logic irq_d;
    logic ack_ok;
    logic serving;
    logic [2:0] vec_grp_q;

    // Group 0 has the highest priority; two groups per status source
    always_comb begin
        grp[0] = |(i_src.status_low[3:0] & ~i_mask.mask_low[3:0]);
        grp[1] = |(i_src.status_low[7:4] & ~i_mask.mask_low[7:4]);
        grp[2] = |(i_src.status_high[3:0] & ~i_mask.mask_high[3:0]);
        grp[3] = |(i_src.status_high[7:4] & ~i_mask.mask_high[7:4]);
        grp[4] = i_cfg.port_in_irq & |(i_src.port_status[3:0] & ~i_mask.port_mask[3:0]);
        grp[5] = i_cfg.port_in_irq & |(i_src.port_status[7:4] & ~i_mask.port_mask[7:4]);
        grp[6] = 1'b0;
        grp[7] = 1'b0;
    end

    assign pending = |grp;
    assign daisy = (i_cfg.cascade_mode == CASCADE_DAISY);
    assign chain_ok = !daisy || i_chain_enable_in;
    assign ack_now = !i_irq_ack_in_n;
    assign ack_fall = ack_now && !ack_q;
    assign ack_rise = !ack_now && ack_q;
    // Acceptance checks the slave address on both chain pins, or chain input in daisy mode
    assign ack_ok = irq_q && (daisy ? i_chain_enable_in :
                    ({i_chain_addr_hi, i_chain_enable_in} == i_cfg.slave_addr));
    assign serving = ack_now || accepted_q || second_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_now;
        end
    end

    // Acknowledge sequencing; two-cycle mode needs a second cycle before clearing
    // The second-cycle flag must survive into the second cycle so its rising edge can clear
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            accepted_q <= 1'b0;
            second_q <= 1'b0;
        end else begin
            if (ack_fall && ack_ok) begin
                accepted_q <= 1'b1;
            end else if (ack_rise && accepted_q) begin
                accepted_q <= 1'b0;
                second_q <= (i_bus_mode == IRQACK_BUS_TWO_CYCLE) && !second_q;
            end
            if (daisy && !i_chain_enable_in && !ack_now) begin
                accepted_q <= 1'b0;
                second_q <= 1'b0;
            end
        end
    end

    always_comb begin
        irq_d = irq_q;
        if (!irq_q && pending && chain_ok && !serving) begin
            irq_d = 1'b1;
        end
        if (irq_q && ack_rise && accepted_q && !pending) begin
            if (i_bus_mode == IRQACK_BUS_STROBED || second_q) begin
                irq_d = 1'b0;
            end
        end
        if (irq_q && !pending && !serving) begin
            irq_d = 1'b0;
        end
        if (daisy && !i_chain_enable_in) begin
            irq_d = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // Vector group frozen at acceptance so a new source cannot change it mid-cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            vec_grp_q <= VEC_GROUP_LSB;
        end else if (ack_fall && ack_ok) begin
            vec_grp_q <= top_group(grp);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_vec_data <= '0;
            o_vec_oe_n <= 1'b1;
        end else begin
            o_vec_data <= {i_cfg.vec_base, vec_grp_q};
            if (i_bus_mode == IRQACK_BUS_STROBED) begin
                o_vec_oe_n <= !(accepted_q && ack_now && !i_strobe_n);
            end else begin
                o_vec_oe_n <= !(accepted_q && ack_now);
            end
        end
    end

    // Request pin drive style; open drain only pulls low
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_irq_out <= 1'b1;
            o_irq_oe_n <= 1'b1;
            o_irq_active <= 1'b0;
        end else begin
            o_irq_active <= irq_d;
            case (i_cfg.drive_mode)
                DRIVE_PUSH_HIGH: begin
                    o_irq_out <= irq_d;
                    o_irq_oe_n <= 1'b0;
                end
                DRIVE_PUSH_LOW: begin
                    o_irq_out <= !irq_d;
                    o_irq_oe_n <= 1'b0;
                end
                default: begin
                    o_irq_out <= 1'b0;
                    o_irq_oe_n <= !irq_d;
                end
            endcase
        end
    end

    // Chain output; driven only in daisy mode, input in slave mode
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_chain_enable_out <= 1'b0;
            o_chain_enable_oe_n <= 1'b1;
        end else begin
            o_chain_enable_oe_n <= !daisy;
            o_chain_enable_out <= i_chain_enable_in && !irq_d;
        end
    end

    // Open-drain ready: released when strobe goes inactive, or when select and acknowledge are both inactive
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_cycle_ready_ack_oe_n <= 1'b1;
        end else if (i_strobe_n || (i_chip_sel_n && i_irq_ack_in_n)) begin
            o_cycle_ready_ack_oe_n <= 1'b1;
        end else if (i_cycle_ready) begin
            o_cycle_ready_ack_oe_n <= 1'b0;
        end
    end

    // Open drain only ever pulls low, so the pin value is a constant register
    always_ff @(posedge i_sys_clk) begin
        o_cycle_ready_ack_out <= 1'b0;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_global_source_status <= '0;
        end else begin
            o_global_source_status <= grp;
        end
    end

    chk_irq_drop_chain: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        daisy && !i_chain_enable_in |=> !o_irq_active) else $error("request kept with chain low");
    chk_chain_out_low: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        o_irq_active |-> !o_chain_enable_out) else $error("chain out high with request");
    chk_ready_release: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        $rose(i_strobe_n) |=> o_cycle_ready_ack_oe_n) else $error("ready held after strobe");
    chk_no_unmasked: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        !pending && !irq_q && !o_irq_active |=> !o_irq_active) else $error("request without source");
    chk_vec_strobe: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_bus_mode == IRQACK_BUS_STROBED && i_strobe_n |=> o_vec_oe_n) else $error("vector without strobe");
    chk_status_follow: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        1'b1 |=> o_global_source_status == $past(grp)) else $error("status stale");
    chk_no_new_irq: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        !irq_q && ack_now |=> !irq_q) else $error("request raised during service");
    chk_ack_accept: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        ack_fall && !irq_q |=> !accepted_q) else $error("acknowledge accepted without request");
    chk_pushhigh: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_cfg.drive_mode == DRIVE_PUSH_HIGH |=> o_irq_out == o_irq_active) else $error("drive polarity");

    cov_accept: cover property (@(posedge i_sys_clk) ack_fall && ack_ok);
    cov_two_cycle: cover property (@(posedge i_sys_clk) second_q && ack_fall);
    cov_chain_abort: cover property (@(posedge i_sys_clk) irq_q && daisy && !i_chain_enable_in);
endmodule : irqack_core

//--- shared/irqack_pkg.sv
package irqack_pkg;
    localparam int unsigned NUM_GROUPS = 8;
    localparam int unsigned VEC_W = 8;
    localparam int unsigned SRC_W = 8;
    localparam logic [1:0] DRIVE_OPEN_DRAIN = 2'h0;
    localparam logic [1:0] DRIVE_PUSH_LOW = 2'h1;
    localparam logic [1:0] DRIVE_PUSH_HIGH = 2'h3;
    localparam logic [1:0] CASCADE_SLAVE = 2'h0;
    localparam logic [1:0] CASCADE_DAISY = 2'h1;
    localparam logic [2:0] VEC_GROUP_LSB = 3'h0;
    localparam logic [SRC_W-1:0] ZERO_SRC = 8'h00;

    typedef enum logic {
        IRQACK_BUS_TWO_CYCLE,
        IRQACK_BUS_STROBED
    } irqack_bus_type;

    typedef struct packed {
        logic [1:0] drive_mode;
        logic [1:0] cascade_mode;
        logic [1:0] slave_addr;
        logic [VEC_W-4:0] vec_base;
        logic port_in_irq;
    } irqack_cfg_type;

    typedef struct packed {
        logic [SRC_W-1:0] status_low;
        logic [SRC_W-1:0] status_high;
        logic [SRC_W-1:0] port_status;
    } irqack_src_type;

    typedef struct packed {
        logic [SRC_W-1:0] mask_low;
        logic [SRC_W-1:0] mask_high;
        logic [SRC_W-1:0] port_mask;
    } irqack_mask_type;
endpackage : irqack_pkg
